/* design/eat_host.sv */
/*
 * Host-side generator of explicit-addressing transmit request frames.
 * Software fills the fields and payload over APB, then starts a frame that
 * is sent byte by byte with valid/ready; an extended status reply is awaited
 * when the frame identifier is non-zero.
 * Assumes the device's byte sink and reply source run on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Each frame opens with start byte 7E at offset zero.
// - Offsets 1-2 carry length of bytes between length field and checksum.
// - Offset 3 carries frame type 0x11 for explicit addressing requests.
// - Offset 5 destination is 0xFFFF for broadcast, else target address.
// - All-zero destination means coordinator; all ones selects short addressing.
// - Offset 13 short address is 0xFFFE for long, broadcast or unknown.
// - Mesh delivery has no short addressing; field is filled with 0xFFFE.
// - Source endpoint at 15, destination at 16; data transfers use 0xE8.
// - Cluster at offset 17; 0x0011 is transparent data for serial transfers.
// - Profile at offset 19; vendor profile 0xC105 for serial data.
// - Payload runs from offset 23 to the byte before the checksum.
// - Checksum is 0xFF minus low byte of sum of offsets 3 onward.
// - Payload length must not exceed the max_payload_query limit.
// - Outer multi-byte fields go most significant byte first.
module eat_host (
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic [7:0]       tx_data_o,
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_valid_i
);
	import eat_pkg::*;

	typedef struct packed {
		eat_state_t                        state;
		eat_mode_t                         mode;
		logic [7:0]                        frame_id;
		logic [63:0]                       dest64;
		logic [15:0]                       dest16;
		logic [7:0]                        src_ep;
		logic [7:0]                        dst_ep;
		logic [15:0]                       cluster;
		logic [15:0]                       profile;
		logic [7:0]                        radius;
		logic [7:0]                        options;
		logic [6:0]                        plen;
		logic [6:0]                        max_plen;
		logic [5:0]                        wr_ptr;
		logic [PAYLOAD_DEPTH-1:0][7:0]     payload;
		logic [7:0]                        off;
		logic [7:0]                        sum;
		logic [7:0]                        tx_data;
		logic                              tx_valid;
		logic                              done;
		logic                              size_err;
		logic                              reply_ok;
		logic                              reply_err;
		logic                              pready;
		logic                              pslverr;
		logic [31:0]                       prdata;
	} eat_host_state_t;

	localparam eat_host_state_t HOST_RST = '{
		state:    ST_IDLE,
		mode:     MODE_U64,
		dest16:   ADDR16_UNKNOWN,
		src_ep:   EP_DATA,
		dst_ep:   EP_DATA,
		cluster:  CLUSTER_TRANSPARENT,
		profile:  PROFILE_VENDOR,
		options:  RST_OPTIONS,
		max_plen: RST_MAX_PLEN,
		default:  '0
	};

	eat_host_state_t q;
	eat_host_state_t n;
	logic            reply_seen;
	logic            reply_match;
	logic            start_req;
	logic            oversize;
	logic [63:0]     eff_dest64;
	logic [15:0]     eff_dest16;
	logic [159:0]    hdr;
	logic [15:0]     len_field;
	logic [7:0]      last_off;
	logic [7:0]      nxt_off;
	logic [7:0]      acc;
	logic [7:0]      pay_idx;
	logic            accept;

	////////////////////////////////////////////////////////////////////////
	// Reply watcher.
	eat_reply_watch u_watch (
		.clk_sys_i     (clk_sys_i),
		.srst_i        (srst_i),
		.rx_data_i     (rx_data_i),
		.rx_valid_i    (rx_valid_i),
		.expect_id_i   (q.frame_id),
		.reply_seen_o  (reply_seen),
		.reply_match_o (reply_match)
	);

	function automatic logic [31:0] read_reg(input eat_host_state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			REG_CTRL:            r[CTRL_MODE_LSB +: 2] = s.mode;
			REG_STATUS: begin
				r[STAT_BUSY_BIT]      = (s.state != ST_IDLE);
				r[STAT_WAIT_BIT]      = (s.state == ST_WAIT);
				r[STAT_DONE_BIT]      = s.done;
				r[STAT_SIZE_ERR_BIT]  = s.size_err;
				r[STAT_REPLY_OK_BIT]  = s.reply_ok;
				r[STAT_REPLY_ERR_BIT] = s.reply_err;
			end
			REG_FRAME_ID:        r[7:0]  = s.frame_id;
			REG_DEST64_HI:       r       = s.dest64[63:32];
			REG_DEST64_LO:       r       = s.dest64[31:0];
			REG_DEST16:          r[15:0] = s.dest16;
			REG_ENDPOINTS:       r[15:0] = {s.dst_ep, s.src_ep};
			REG_CLUSTER_PROFILE: r       = {s.profile, s.cluster};
			REG_RADIUS_OPTIONS:  r[15:0] = {s.options, s.radius};
			REG_PAYLOAD_LEN:     r[6:0]  = s.plen;
			REG_MAX_PAYLOAD:     r[6:0]  = s.max_plen;
			REG_PAYLOAD_PTR:     r[5:0]  = s.wr_ptr;
			default:             r       = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= REG_PAYLOAD_DATA);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Field values as they go on the wire.
	always_comb begin
		unique case (q.mode)
			MODE_BCAST: eff_dest64 = ADDR_BCAST64;
			MODE_U16:   eff_dest64 = ADDR_USE16;
			MODE_COORD: eff_dest64 = ADDR_COORD64;
			MODE_U64:   eff_dest64 = q.dest64;
		endcase
		// Short addressing only when asked for and not on mesh delivery.
		if (q.mode == MODE_U16 && q.options[7:6] != DELIVERY_MESH) begin
			eff_dest16 = q.dest16;
		end else begin
			eff_dest16 = ADDR16_UNKNOWN;
		end
	end

	// The software-loaded endpoints, cluster, profile, radius and options go
	// out unchanged; zero radius and options are legal and select defaults.
	assign hdr       = {FRAME_TYPE_EXPLICIT, q.frame_id, eff_dest64, eff_dest16, q.src_ep, q.dst_ep,
	                    q.cluster, q.profile, q.radius, q.options};
	assign len_field = HDR_BYTES + {9'h000, q.plen};
	assign last_off  = OFF_PAYLOAD + {1'b0, q.plen};
	assign nxt_off   = 8'(q.off + 8'h01);
	assign acc       = (q.off >= OFF_TYPE) ? 8'(q.sum + q.tx_data) : q.sum;
	assign pay_idx   = 8'(nxt_off - OFF_PAYLOAD);
	assign accept    = q.tx_valid && tx_ready_i;
	assign start_req = psel_i && penable_i && pwrite_i && q.pready && paddr_i == REG_CTRL
	                   && pwdata_i[CTRL_START_BIT];
	assign oversize  = (q.plen > q.max_plen) || (q.plen > 7'(PAYLOAD_DEPTH));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		// APB: one wait state, read data captured on the same edge that pready rises.
		if (psel_i && penable_i && !q.pready) begin
			n.pready  = 1'b1;
			n.prdata  = read_reg(q, paddr_i);
			n.pslverr = !reg_mapped(paddr_i);
		end else begin
			n.pready  = 1'b0;
			n.pslverr = 1'b0;
		end
		// Field writes are ignored while a frame is out so it stays coherent.
		if (psel_i && penable_i && pwrite_i && q.pready && q.state == ST_IDLE) begin
			unique case (paddr_i)
				REG_CTRL:            n.mode = eat_mode_t'(pwdata_i[CTRL_MODE_LSB +: 2]);
				REG_FRAME_ID:        n.frame_id = pwdata_i[7:0];
				REG_DEST64_HI:       n.dest64[63:32] = pwdata_i;
				REG_DEST64_LO:       n.dest64[31:0] = pwdata_i;
				REG_DEST16:          n.dest16 = pwdata_i[15:0];
				REG_ENDPOINTS:       {n.dst_ep, n.src_ep} = pwdata_i[15:0];
				REG_CLUSTER_PROFILE: {n.profile, n.cluster} = pwdata_i;
				REG_RADIUS_OPTIONS:  {n.options, n.radius} = pwdata_i[15:0];
				REG_PAYLOAD_LEN:     n.plen = pwdata_i[6:0];
				REG_MAX_PAYLOAD:     n.max_plen = pwdata_i[6:0];
				REG_PAYLOAD_PTR:     n.wr_ptr = pwdata_i[5:0];
				REG_PAYLOAD_DATA: begin
					n.payload[q.wr_ptr] = pwdata_i[7:0];
					n.wr_ptr            = 6'(q.wr_ptr + 6'h01);
				end
				default: ;
			endcase
		end

		unique case (q.state)
			ST_IDLE: begin
				if (start_req) begin
					n.done      = 1'b0;
					n.reply_ok  = 1'b0;
					n.reply_err = 1'b0;
					if (oversize) begin
						n.size_err = 1'b1;
					end else begin
						n.size_err = 1'b0;
						n.state    = ST_SEND;
						n.off      = OFF_START;
						n.sum      = 8'h00;
						n.tx_data  = START_DELIM;
						n.tx_valid = 1'b1;
					end
				end
			end
			ST_SEND: begin
				if (accept) begin
					if (q.off == last_off) begin
						n.tx_valid = 1'b0;
						n.done     = 1'b1;
						// A zero identifier owes no reply, so nothing is awaited.
						n.state    = (q.frame_id != 8'h00) ? ST_WAIT : ST_IDLE;
					end else begin
						n.off = nxt_off;
						n.sum = acc;
						if (nxt_off == OFF_LEN_HI) begin
							n.tx_data = len_field[15:8];
						end else if (nxt_off == OFF_LEN_LO) begin
							n.tx_data = len_field[7:0];
						end else if (nxt_off < OFF_PAYLOAD) begin
							n.tx_data = eat_pick_byte(hdr, 8'(nxt_off - OFF_TYPE));
						end else if (nxt_off < last_off) begin
							n.tx_data = q.payload[pay_idx[5:0]];
						end else begin
							n.tx_data = 8'(CSUM_BASE - acc);
						end
					end
				end
			end
			ST_WAIT: begin
				if (reply_seen) begin
					n.reply_ok  = reply_match;
					n.reply_err = !reply_match;
					n.state     = ST_IDLE;
				end else if (psel_i && penable_i && pwrite_i && q.pready && paddr_i == REG_CTRL
				             && pwdata_i[CTRL_ABORT_BIT]) begin
					// A lost reply would otherwise hold the host here forever.
					n.state = ST_IDLE;
				end
			end
			default: n.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= HOST_RST;
		end else begin
			q <= n;
		end
	end

	assign prdata_o   = q.prdata;
	assign pready_o   = q.pready;
	assign pslverr_o  = q.pslverr;
	assign tx_data_o  = q.tx_data;
	assign tx_valid_o = q.tx_valid;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	logic [7:0] chk_run;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || (accept && q.off == OFF_START)) begin
			chk_run <= 8'h00;
		end else if (accept && q.off >= OFF_TYPE) begin
			chk_run <= 8'(chk_run + q.tx_data);
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	sequence s_byte_offered;
		q.tx_valid && !tx_ready_i;
	endsequence

	sequence s_start_ok;
		q.state == ST_IDLE && start_req && !oversize;
	endsequence

	AST_START_DELIM: assert property (s_start_ok |=> q.tx_valid && q.off == OFF_START && q.tx_data == 8'h7e)
		else $error("Frame did not open with the start byte.");
	AST_LEN_BYTES: assert property (q.tx_valid && q.off == OFF_LEN_LO |-> q.tx_data == 8'(8'h14 + {1'b0, q.plen}))
		else $error("Length byte does not match the payload length.");
	AST_TYPE_BYTE: assert property (accept && q.off == OFF_LEN_LO |=> q.off == OFF_TYPE && q.tx_data == 8'h11)
		else $error("Frame type byte is wrong.");
	AST_BCAST_ADDR: assert property (q.tx_valid && q.mode == MODE_BCAST && q.off == OFF_DEST64_LAST
	                                 |-> q.tx_data == 8'hff)
		else $error("Broadcast address low byte is wrong.");
	AST_USE16_ADDR: assert property (q.tx_valid && q.mode == MODE_U16 && q.off == OFF_DEST64 |-> q.tx_data == 8'hff)
		else $error("Short addressing did not fill the long address with ones.");
	AST_MESH_DEST16: assert property (q.tx_valid && q.options[7:6] == DELIVERY_MESH && q.off == OFF_DEST16
	                                  |-> q.tx_data == 8'hff)
		else $error("Mesh delivery sent a short address.");
	AST_CHECKSUM: assert property (accept && q.state == ST_SEND && q.off == last_off
	                               |-> 8'(chk_run + q.tx_data) == 8'hff)
		else $error("Checksum does not complete the byte sum to 0xff.");
	AST_OVERSIZE: assert property (q.state == ST_IDLE && start_req && oversize
	                               |=> q.state == ST_IDLE && q.size_err && !q.tx_valid)
		else $error("Oversized payload was not refused.");
	AST_HOLD_BYTE: assert property (s_byte_offered |=> q.tx_valid && $stable(q.tx_data) && $stable(q.off))
		else $error("Offered byte changed before it was taken.");
	AST_NO_REPLY_WAIT: assert property (accept && q.state == ST_SEND && q.off == last_off && q.frame_id == 8'h00
	                                    |=> q.state == ST_IDLE ##1 q.state != ST_WAIT)
		else $error("Host waited for a reply to a zero identifier.");

endmodule // eat_host

`default_nettype wire

/* design/eat_pkg.sv */
/*
 * Constants, field layouts and types shared by the explicit-addressing
 * transmit request host and its reply watcher.
 * Assumes a single 100 MHz clock domain and a byte-wide link to the device.
 */
`default_nettype none

package eat_pkg;

	////////////////////////////////////////////////////////////////////////
	// Frame layout.
	localparam int unsigned PAYLOAD_DEPTH        = 64;
	localparam logic [7:0]  START_DELIM          = 8'h7e;
	localparam logic [7:0]  FRAME_TYPE_EXPLICIT  = 8'h11;
	localparam logic [7:0]  FRAME_TYPE_EXT_STAT  = 8'h8b;
	localparam logic [7:0]  OFF_START            = 8'h00;
	localparam logic [7:0]  OFF_LEN_HI           = 8'h01;
	localparam logic [7:0]  OFF_LEN_LO           = 8'h02;
	localparam logic [7:0]  OFF_TYPE             = 8'h03;
	localparam logic [7:0]  OFF_FRAME_ID         = 8'h04;
	localparam logic [7:0]  OFF_DEST64           = 8'h05;
	localparam logic [7:0]  OFF_DEST64_LAST      = 8'h0c;
	localparam logic [7:0]  OFF_DEST16           = 8'h0d;
	localparam logic [7:0]  OFF_PAYLOAD          = 8'h17;
	localparam logic [15:0] HDR_BYTES            = 16'h0014;
	localparam logic [7:0]  CSUM_BASE            = 8'hff;
	localparam logic [2:0]  RX_CNT_TYPE          = 3'h3;
	localparam logic [2:0]  RX_CNT_ID            = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Field values.
	localparam logic [63:0] ADDR_BCAST64         = 64'h0000_0000_0000_ffff;
	localparam logic [63:0] ADDR_COORD64         = 64'h0000_0000_0000_0000;
	localparam logic [63:0] ADDR_USE16           = 64'hffff_ffff_ffff_ffff;
	localparam logic [15:0] ADDR16_UNKNOWN       = 16'hfffe;
	localparam logic [7:0]  EP_DATA              = 8'he8;
	localparam logic [15:0] CLUSTER_TRANSPARENT  = 16'h0011;
	localparam logic [15:0] PROFILE_VENDOR       = 16'hc105;
	localparam logic [1:0]  DELIVERY_MESH        = 2'h3;
	localparam logic [6:0]  RST_MAX_PLEN         = 7'h40;
	localparam logic [7:0]  RST_OPTIONS          = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Register map of the host's own APB slave.
	localparam logic [7:0]  REG_CTRL             = 8'h00;
	localparam logic [7:0]  REG_STATUS           = 8'h04;
	localparam logic [7:0]  REG_FRAME_ID         = 8'h08;
	localparam logic [7:0]  REG_DEST64_HI        = 8'h0c;
	localparam logic [7:0]  REG_DEST64_LO        = 8'h10;
	localparam logic [7:0]  REG_DEST16           = 8'h14;
	localparam logic [7:0]  REG_ENDPOINTS        = 8'h18;
	localparam logic [7:0]  REG_CLUSTER_PROFILE  = 8'h1c;
	localparam logic [7:0]  REG_RADIUS_OPTIONS   = 8'h20;
	localparam logic [7:0]  REG_PAYLOAD_LEN      = 8'h24;
	localparam logic [7:0]  REG_MAX_PAYLOAD      = 8'h28;
	localparam logic [7:0]  REG_PAYLOAD_PTR      = 8'h2c;
	localparam logic [7:0]  REG_PAYLOAD_DATA     = 8'h30;
	localparam int unsigned CTRL_START_BIT       = 0;
	localparam int unsigned CTRL_ABORT_BIT       = 1;
	localparam int unsigned CTRL_MODE_LSB        = 4;
	localparam int unsigned STAT_BUSY_BIT        = 0;
	localparam int unsigned STAT_WAIT_BIT        = 1;
	localparam int unsigned STAT_DONE_BIT        = 2;
	localparam int unsigned STAT_SIZE_ERR_BIT    = 3;
	localparam int unsigned STAT_REPLY_OK_BIT    = 4;
	localparam int unsigned STAT_REPLY_ERR_BIT   = 5;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b11
	} eat_state_t;

	typedef enum logic [1:0] {
		MODE_U64   = 2'b00,
		MODE_BCAST = 2'b01,
		MODE_U16   = 2'b10,
		MODE_COORD = 2'b11
	} eat_mode_t;

	// Header bytes from the type field onward, most significant first.
	function automatic logic [7:0] eat_pick_byte(input logic [159:0] hdr, input logic [7:0] idx);
		logic [159:0] s;
		s = hdr << {idx, 3'b000};
		return s[159:152];
	endfunction

endpackage

`default_nettype wire

/* design/eat_reply_watch.sv */
/*
 * Watches the byte stream coming back from the device for an extended
 * transmit status frame and compares its identifier with the one sent.
 * Assumes the reply bytes come from logic on the same clock, unescaped.
 */
`timescale 1ns/1ps
`default_nettype none

module eat_reply_watch (
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] expect_id_i,
	output logic            reply_seen_o,
	output logic            reply_match_o
);
	import eat_pkg::*;

	typedef struct packed {
		logic [2:0]  cnt;
		logic [15:0] left;
		logic        type_ok;
		logic        seen;
		logic        match;
	} eat_watch_state_t;

	eat_watch_state_t q;
	eat_watch_state_t n;

	////////////////////////////////////////////////////////////////////////
	// Only the type and identifier are checked; the rest of the status frame,
	// checksum included, is skipped by its length field, so a start byte
	// value inside it cannot restart the hunt and swallow the next reply.
	always_comb begin
		n      = q;
		n.seen = 1'b0;
		if (rx_valid_i) begin
			if (q.cnt == 3'h0) begin
				if (rx_data_i == START_DELIM) begin
					n.cnt = 3'h1;
				end
			end else if (q.cnt == 3'h1) begin
				n.left[15:8] = rx_data_i;
				n.cnt        = 3'h2;
			end else if (q.cnt == 3'h2) begin
				n.left[7:0] = rx_data_i;
				n.cnt       = RX_CNT_TYPE;
			end else if (q.cnt == RX_CNT_TYPE) begin
				n.type_ok = (rx_data_i == FRAME_TYPE_EXT_STAT);
				n.cnt     = RX_CNT_ID;
			end else if (q.cnt == RX_CNT_ID) begin
				n.seen  = q.type_ok;
				n.match = (rx_data_i == expect_id_i);
				// Bytes still to come after the identifier, checksum excluded.
				n.left  = 16'(q.left - 16'h0002);
				n.cnt   = (q.left < 16'h0002) ? 3'h0 : 3'h5;
			end else if (q.left == 16'h0000) begin
				n.cnt = 3'h0;
			end else begin
				n.left = 16'(q.left - 16'h0001);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign reply_seen_o  = q.seen;
	assign reply_match_o = q.match;

endmodule // eat_reply_watch

`default_nettype wire

/* verification/eat_dev_model.sv */
/*
 * Behavioural device that swallows request frames and answers with status replies.
 * Assumes the host drives the byte link on the same clock as this model.
 */
`timescale 1ns/1ps
`default_nettype none

module eat_dev_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	input  wire logic       stall_i,
	input  wire logic       bad_id_i
);
	logic [7:0] frame[$];
	logic [7:0] last[$];
	logic       ok = 1'b0;
	int         frames = 0;

	// Endpoint, cluster, profile, radius and option bytes are kept as received; with no radio behind
	// the model, their roles and defaults need no action here.
	initial begin
		logic [7:0] lf, s, rid;
		logic [7:0] rep[$];
		lf = 8'h3b;
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		forever begin
			@(posedge clk_sys_i);
			if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
				if (frame.size() != 0 || tx_data_i == 8'h7e) frame.push_back(tx_data_i);
				if (frame.size() > 3 && frame.size() == int'({frame[1], frame[2]}) + 4) begin
					s = 8'h00;
					foreach (frame[i]) if (i >= 3) s += frame[i];
					ok = (s == 8'hff);
					if (ok) last = frame;
					frames++;
					rid = bad_id_i ? ~frame[4] : frame[4];
					if (ok && frame[3] == 8'h11 && frame[4] != 8'h00) begin
						rep = {8'h7e, 8'h00, 8'h07, 8'h8b, rid, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff - 8'h8b - rid};
						foreach (rep[i]) begin
							rx_valid_o <= 1'b1;
							rx_data_o <= rep[i];
							@(posedge clk_sys_i);
							rx_valid_o <= 1'b0;
							rx_data_o <= ~rep[i];
							@(posedge clk_sys_i);
						end
					end
					frame = {};
				end
			end
			lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
			tx_ready_o <= !stall_i || lf[0];
		end
	end
endmodule // eat_dev_model

`default_nettype wire

/* verification/tb_top.sv */
/*
 * Self-checking bench: programs the host over APB and checks every frame byte and status.
 * Assumes the package, design and device model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import eat_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, tx_valid, tx_ready, rx_valid;
	logic        stall = 1'b0;
	logic        bad_id = 1'b0;
	logic [7:0]  tx_data, rx_data;
	logic [7:0]  lfsr = 8'h5c;
	int          miscompares = 0;
	int          checks = 0;
	int          f0;

	eat_host i_dut (.clk_sys_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_data_i(rx_data), .rx_valid_i(rx_valid));
	eat_dev_model i_dev (.clk_sys_i(clk), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .stall_i(stall), .bad_id_i(bad_id));

	initial forever #5 clk = ~clk;

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task automatic send_frame(input logic [1:0] mode, input int n, input logic bad, input logic abort);
		logic [7:0]  q[$];
		logic [7:0]  id, sum, rad, opt, src, dst, p;
		logic [63:0] d64, e64;
		logic [15:0] d16, e16, clus, prof;
		logic [31:0] st;
		logic        e;
		int          k;
		id = (mode == 2'h3) ? 8'h00 : (rnd() | 8'h01);
		d64 = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		d16 = {rnd(), rnd()};
		clus = {rnd(), rnd()};
		prof = {rnd(), rnd()};
		src = rnd();
		dst = rnd();
		rad = rnd();
		opt = rnd();
		wr(REG_FRAME_ID, {24'h0, id});
		wr(REG_DEST64_HI, d64[63:32]);
		wr(REG_DEST64_LO, d64[31:0]);
		wr(REG_DEST16, {16'h0, d16});
		wr(REG_ENDPOINTS, {16'h0, dst, src});
		wr(REG_CLUSTER_PROFILE, {prof, clus});
		wr(REG_RADIUS_OPTIONS, {16'h0, opt, rad});
		wr(REG_PAYLOAD_LEN, 32'(n));
		wr(REG_PAYLOAD_PTR, 32'h0);
		e64 = (mode == 2'h1) ? ADDR_BCAST64 : (mode == 2'h2) ? ADDR_USE16 : (mode == 2'h3) ? ADDR_COORD64 : d64;
		e16 = (mode == 2'h2 && opt[7:6] != DELIVERY_MESH) ? d16 : ADDR16_UNKNOWN;
		q = {FRAME_TYPE_EXPLICIT, id};
		for (k = 7; k >= 0; k--) q.push_back(e64[8*k+:8]);
		q = {q, e16[15:8], e16[7:0], src, dst, clus[15:8], clus[7:0], prof[15:8], prof[7:0], rad, opt};
		for (k = 0; k < n; k++) begin
			p = rnd();
			q.push_back(p);
			wr(REG_PAYLOAD_DATA, {24'h0, p});
		end
		sum = 8'h00;
		foreach (q[i]) sum += q[i];
		q = {START_DELIM, 8'h00, 8'(q.size()), q, 8'hff - sum};
		bad_id <= bad;
		f0 = i_dev.frames;
		wr(REG_CTRL, {26'h0, mode, 4'h1});
		k = 0;
		while (i_dev.frames == f0 && k < 2000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 2000) miscompares++;
		chk({31'h0, i_dev.ok}, 32'h1);
		chk(32'(i_dev.last.size()), 32'(q.size()));
		foreach (q[i]) chk({24'h0, i_dev.last[i]}, {24'h0, q[i]});
		// Abort lands while the reply is still on its way; the late reply must be ignored.
		if (abort) wr(REG_CTRL, 32'h2);
		k = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0, st, e);
			k++;
		end while (st[0] !== 1'b0 && k < 100);
		chk({26'h0, st[5:0]}, {26'h0, bad && id != 8'h00 && !abort, !bad && id != 8'h00 && !abort, 4'h4});
		rdchk(REG_CTRL, {26'h0, mode, 4'h0}, 1'b0);
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdchk(REG_CLUSTER_PROFILE, 32'hc105_0011, 1'b0);
		rdchk(REG_DEST16, 32'h0000_fffe, 1'b0);
		rdchk(REG_ENDPOINTS, 32'h0000_e8e8, 1'b0);
		rdchk(REG_MAX_PAYLOAD, 32'h0000_0040, 1'b0);
		rdchk(8'h34, 32'h0, 1'b1);
		rdchk(8'h06, 32'h0, 1'b1);
		for (int m = 0; m < 8; m++) begin
			stall <= m[0];
			send_frame(m[1:0], m + 1, m == 5, m == 6);
		end
		wr(REG_MAX_PAYLOAD, 32'h4);
		send_frame(2'h0, 4, 1'b0, 1'b0);
		f0 = i_dev.frames;
		wr(REG_PAYLOAD_LEN, 32'h5);
		wr(REG_CTRL, 32'h1);
		rdchk(REG_STATUS, 32'h8, 1'b0);
		chk(32'(i_dev.frames), 32'(f0));
		report_and_stop();
	end
endmodule // tb_top

`default_nettype wire
